// [logic/scpmc_top.sv]
/*
  System clock selection, high-speed oscillator control and halt power modes.

  Contents
    Two-flop release of the asynchronous reset; all other logic uses the copy.
    System clock control register: select field, fast keep bit, slow keep bit.
    Oscillator control register: frequency field, stable flag, enable bit.
    Settle counter that gates the stable flag after enable or retune.
    Frequency hand-over that follows the request only once stable.
    Power mode state: run, sleep and three idle modes, chosen on halt.
    Entry pulses for the power-down flag, time-out clear and watchdog clear.
    Oscillator, sub clock and watchdog clock run levels per mode.
    Shared fast divider and tick selection for the seven fast codes.
    Glitch-free source switch with a gap between old and new periods.
    System clock tick output, suppressed while the core is held.
    Register read multiplexer with a registered read data port.

  Register map
    Address 0: select in bits 7..5, fast keep bit 1, slow keep bit 0.
    Address 1: frequency in bits 3..2, stable bit 1 (read only), enable bit 0.
    Addresses 2 and 3 are unmapped: writes dropped, reads give zero.
    Unused bits always read as zero.

  Register port timing
    A write lands on the edge that samples the write strobe.
    Read data stand in the cycle after the read strobe, zero otherwise.
    The port never stalls; strobes may follow back to back.

  Clock switch behaviour
    A switch starts only on a tick of the old source and with the target ready.
    Ticks then stop until the first tick of the new source.
    That tick makes the new source active; output ticks resume after it.
    A target that never becomes ready keeps the old source forever.

  Halt behaviour
    A halt in run picks the mode from the two keep bits.
    A halt while already halted is ignored.
    Any wake input returns to run on the next edge.
    Control registers are never written by mode changes; the stable flag clears while the fast oscillator is stopped.

  Assumptions
    Oscillator ticks and ready levels arrive synchronous to clk_sys_in.
    Each oscillator tick is one cycle wide and never back to back faster
    than the divider can count.
    The system clock leaves as a one-cycle tick per system clock period.
    Wake inputs are levels or pulses of at least one cycle.
    The watchdog enable level comes from the watchdog block unchanged.
*/
// Notes on behaviour
// - Select field picks divided fast or sub clock
// - Unused system control bits read zero
// - Fast keep bit holds fast oscillator in halt
// - Slow keep bit holds slow oscillator in halt
// - Frequency field: 2, 4, 8, 2 MHz
// - New fast frequency applied once stable
// - Enabling clears stable flag, set when settled
// - Enable bit runs fast oscillator, resets one
// - Halt with both keeps zero enters sleep
// - Halt, fast zero slow one: idle 0
// - Halt with both keeps one: idle 1
// - Halt, fast one slow zero: idle 2
// - Low power modes keep all state except the stable flag
// - Halt sets power-down, clears time-out flag
// - Halt clears the watchdog counter
// - Slow switch completes once slow oscillator stable
// - Fast return waits for stable fast oscillator
// - Sleep keeps watchdog clock only when enabled
// - Wake on port edge, interrupt or overflow
`default_nettype none
module scpmc_top (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_n_in,
  input  wire logic [scpmc_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [scpmc_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [scpmc_pkg::DATA_W-1:0] reg_rdata_out,
  input  wire logic                        hs_osc_tick_in,
  input  wire logic                        hs_osc_ready_in,
  input  wire logic                        ls_osc_tick_in,
  input  wire logic                        ls_osc_ready_in,
  input  wire logic                        halt_in,
  input  wire logic                        port_fall_wake_in,
  input  wire logic                        irq_wake_in,
  input  wire logic                        wdt_overflow_in,
  input  wire logic                        wdt_enabled_in,
  output logic                             sys_clk_tick_out,
  output logic                             hs_osc_run_out,
  output logic      [1:0]                  hs_freq_sel_out,
  output logic                             ls_osc_run_out,
  output logic                             sub_clk_run_out,
  output logic                             wdt_clk_run_out,
  output logic                             cpu_hold_out,
  output logic      [2:0]                  power_mode_out,
  output logic                             power_down_set_out,
  output logic                             timeout_clear_out,
  output logic                             wdt_clear_out
);

  logic                            rst_meta_q;
  logic                            rst_sync_q;
  logic [2:0]                      clk_sel_q;
  logic                            hs_keep_q;
  logic                            ls_keep_q;
  logic [1:0]                      hs_freq_q;
  logic                            hs_en_q;
  logic                            hs_stable_q;
  logic [scpmc_pkg::SETTLE_W-1:0]  settle_cnt_q;
  logic [1:0]                      hs_freq_act_q;
  scpmc_pkg::scpmc_mode_e          mode_q;
  logic [2:0]                      act_sel_q;
  logic                            sw_gap_q;
  logic [5:0]                      div_cnt_q;
  logic                            wr_sys;
  logic                            wr_hs;
  logic                            low_power;
  logic                            wake;
  logic                            hs_tick;
  logic                            src_tick;
  logic                            new_tick;
  logic                            new_ready;
  logic [scpmc_pkg::DATA_W-1:0]    rd_mux;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Write decode; unmapped addresses match neither and are dropped
  assign wr_sys = reg_wr_in && (reg_addr_in == scpmc_pkg::SYS_CLK_CTRL_ADDR);
  assign wr_hs  = reg_wr_in && (reg_addr_in == scpmc_pkg::HS_OSC_CTRL_ADDR);

  // System clock control register
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      clk_sel_q <= scpmc_pkg::CLK_SEL_RESET;
      hs_keep_q <= 1'b0;
      ls_keep_q <= 1'b0;
    end else if (wr_sys) begin
      clk_sel_q <= reg_wdata_in[scpmc_pkg::CLK_SEL_LSB +: 3];
      hs_keep_q <= reg_wdata_in[scpmc_pkg::HS_KEEP_BIT];
      ls_keep_q <= reg_wdata_in[scpmc_pkg::LS_KEEP_BIT];
    end
  end

  // Oscillator control register, writable bits only
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hs_freq_q <= scpmc_pkg::HS_FREQ_2MHZ;
      hs_en_q   <= scpmc_pkg::HS_EN_RESET;
    end else if (wr_hs) begin
      hs_freq_q <= reg_wdata_in[scpmc_pkg::HS_FREQ_LSB +: 2];
      hs_en_q   <= reg_wdata_in[scpmc_pkg::HS_EN_BIT];
    end
  end

  // Stable flag: cleared on enable or frequency change, set after settling
  // Clear wins over set so a retune never reports a stale stable state
  // Counter holds at its end value until the ready level arrives
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hs_stable_q  <= 1'b0;
      settle_cnt_q <= '0;
    end else if ((wr_hs && reg_wdata_in[scpmc_pkg::HS_EN_BIT] && !hs_en_q) ||
                 (wr_hs && reg_wdata_in[scpmc_pkg::HS_FREQ_LSB +: 2] != hs_freq_q) ||
                 !hs_osc_run_out) begin
      hs_stable_q  <= 1'b0;
      settle_cnt_q <= '0;
    end else if (settle_cnt_q != scpmc_pkg::SETTLE_W'(scpmc_pkg::HS_SETTLE_CYC)) begin
      settle_cnt_q <= settle_cnt_q + 1'b1;
    end else if (hs_osc_ready_in) begin
      hs_stable_q <= 1'b1;
    end
  end

  // Frequency request reaches the oscillator only once it reports stable
  // The flag drops on the same edge that takes a retune write, so the old code is kept
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hs_freq_act_q <= scpmc_pkg::HS_FREQ_2MHZ;
    end else if (hs_stable_q) begin
      hs_freq_act_q <= hs_freq_q;
    end
  end

  // Code 3 is a second 2 MHz code
  always_comb begin
    case (hs_freq_act_q)
      scpmc_pkg::HS_FREQ_4MHZ: hs_freq_sel_out = scpmc_pkg::HS_FREQ_4MHZ;
      scpmc_pkg::HS_FREQ_8MHZ: hs_freq_sel_out = scpmc_pkg::HS_FREQ_8MHZ;
      scpmc_pkg::HS_FREQ_ALT2: hs_freq_sel_out = scpmc_pkg::HS_FREQ_2MHZ;
      default:                 hs_freq_sel_out = scpmc_pkg::HS_FREQ_2MHZ;
    endcase
  end

  // Wake sources
  assign wake      = port_fall_wake_in || irq_wake_in || wdt_overflow_in;
  assign low_power = (mode_q != scpmc_pkg::SCPMC_RUN);

  // Power mode from keep bits on halt
  // Keep bits are read as they stand at the halt edge
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_q <= scpmc_pkg::SCPMC_RUN;
    end else begin
      case (mode_q)
        scpmc_pkg::SCPMC_RUN: begin
          if (halt_in) begin
            case ({hs_keep_q, ls_keep_q})
              2'h0:    mode_q <= scpmc_pkg::SCPMC_SLEEP;
              2'h1:    mode_q <= scpmc_pkg::SCPMC_IDLE_MODE_0;
              2'h3:    mode_q <= scpmc_pkg::SCPMC_IDLE_MODE_1;
              default: mode_q <= scpmc_pkg::SCPMC_IDLE_MODE_2;
            endcase
          end
        end
        default: begin
          if (wake) begin
            mode_q <= scpmc_pkg::SCPMC_RUN;
          end
        end
      endcase
    end
  end

  // Entry pulses for status flags and watchdog
  // Issued only from run, so a repeated halt gives no second pulse
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      power_down_set_out <= 1'b0;
      timeout_clear_out  <= 1'b0;
      wdt_clear_out      <= 1'b0;
    end else begin
      power_down_set_out <= halt_in && !low_power;
      timeout_clear_out  <= halt_in && !low_power;
      wdt_clear_out      <= halt_in && !low_power;
    end
  end

  // Oscillator and clock gating per mode; registers are never touched here
  // Outputs trail the mode register by one edge, matching power_mode_out
  // Slow oscillator also runs in sleep while the watchdog needs its clock
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hs_osc_run_out  <= 1'b1;
      ls_osc_run_out  <= 1'b1;
      sub_clk_run_out <= 1'b1;
      wdt_clk_run_out <= 1'b1;
      cpu_hold_out    <= 1'b0;
      power_mode_out  <= 3'h0;
    end else begin
      hs_osc_run_out  <= hs_en_q && (!low_power || hs_keep_q);
      ls_osc_run_out  <= !low_power || ls_keep_q ||
                         (mode_q == scpmc_pkg::SCPMC_SLEEP && wdt_enabled_in);
      sub_clk_run_out <= !low_power || ls_keep_q;
      wdt_clk_run_out <= (mode_q != scpmc_pkg::SCPMC_SLEEP) || wdt_enabled_in;
      cpu_hold_out    <= low_power;
      power_mode_out  <= mode_q;
    end
  end

  // Fast clock divider
  // One shared counter keeps all divided ticks aligned to each other
  assign hs_tick = hs_osc_tick_in && hs_osc_run_out;
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      div_cnt_q <= '0;
    end else if (hs_tick) begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Tick of a source code: fast clock divided by 2^code, or sub clock
  function automatic logic code_tick(input logic [2:0] code, input logic [5:0] cnt,
                                     input logic hs_t, input logic ls_t);
    logic [5:0] mask;
    mask = 6'h3F >> (3'h6 - code);
    if (code == scpmc_pkg::CLK_SEL_SUB) begin
      code_tick = ls_t;
    end else if (code == 3'h0) begin
      code_tick = hs_t;
    end else begin
      code_tick = hs_t && ((cnt & mask) == mask);
    end
  endfunction

  assign src_tick  = code_tick(act_sel_q, div_cnt_q, hs_tick, ls_osc_tick_in);
  assign new_tick  = code_tick(clk_sel_q, div_cnt_q, hs_tick, ls_osc_tick_in);
  assign new_ready = (clk_sel_q == scpmc_pkg::CLK_SEL_SUB) ? ls_osc_ready_in
                                                           : hs_stable_q;

  // Glitch-free switch: finish old period, hold, start on new tick
  // The gap hides the partial period of the new source
  // A select written during the gap retargets it to the latest code
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      act_sel_q <= scpmc_pkg::CLK_SEL_RESET;
      sw_gap_q  <= 1'b0;
    end else if (sw_gap_q) begin
      if (new_tick) begin
        act_sel_q <= clk_sel_q;
        sw_gap_q  <= 1'b0;
      end
    end else if (clk_sel_q != act_sel_q && new_ready && src_tick) begin
      sw_gap_q <= 1'b1;
    end
  end

  // System clock tick, stopped while halted
  // Registered so the tick never depends on the oscillator input path
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sys_clk_tick_out <= 1'b0;
    end else begin
      sys_clk_tick_out <= src_tick && !sw_gap_q && !low_power;
    end
  end

  // Read data, reserved bits zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr_in)
      scpmc_pkg::SYS_CLK_CTRL_ADDR: begin
        rd_mux[scpmc_pkg::CLK_SEL_LSB +: 3] = clk_sel_q;
        rd_mux[scpmc_pkg::HS_KEEP_BIT]      = hs_keep_q;
        rd_mux[scpmc_pkg::LS_KEEP_BIT]      = ls_keep_q;
      end
      scpmc_pkg::HS_OSC_CTRL_ADDR: begin
        rd_mux[scpmc_pkg::HS_FREQ_LSB +: 2]  = hs_freq_q;
        rd_mux[scpmc_pkg::HS_STABLE_BIT]     = hs_stable_q;
        rd_mux[scpmc_pkg::HS_EN_BIT]         = hs_en_q;
      end
      default: rd_mux = '0;
    endcase
  end

  // Read data stand one cycle after the strobe
  // Zero outside a read so stale data never linger on the port
  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : '0;
    end
  end

endmodule
`default_nettype wire

// [logic/scpmc_pkg.sv]
/*
  Constants for the system clock and power mode controller.
  Assumes a single 100 MHz system clock and an 8-bit register port.
*/
`default_nettype none
package scpmc_pkg;
  // Register port
  localparam int unsigned ADDR_W   = 2;
  localparam int unsigned DATA_W   = 8;
  localparam logic [1:0] SYS_CLK_CTRL_ADDR = 2'h0;
  localparam logic [1:0] HS_OSC_CTRL_ADDR  = 2'h1;
  // System clock control fields
  localparam int unsigned CLK_SEL_LSB   = 5;
  localparam int unsigned HS_KEEP_BIT   = 1;
  localparam int unsigned LS_KEEP_BIT   = 0;
  localparam logic [2:0] CLK_SEL_RESET  = 3'h0;
  localparam logic [2:0] CLK_SEL_SUB    = 3'h7;
  // High-speed oscillator control fields
  localparam int unsigned HS_FREQ_LSB   = 2;
  localparam int unsigned HS_STABLE_BIT = 1;
  localparam int unsigned HS_EN_BIT     = 0;
  localparam logic [1:0] HS_FREQ_2MHZ   = 2'h0;
  localparam logic [1:0] HS_FREQ_4MHZ   = 2'h1;
  localparam logic [1:0] HS_FREQ_8MHZ   = 2'h2;
  localparam logic [1:0] HS_FREQ_ALT2   = 2'h3;
  localparam logic       HS_EN_RESET    = 1'b1;
  // Oscillator settle time before the ready input is believed
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HS_SETTLE_NS  = 160;
  localparam int unsigned HS_SETTLE_CYC = (HS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 5;
  // Power modes
  typedef enum logic [2:0] {
    SCPMC_RUN,
    SCPMC_SLEEP,
    SCPMC_IDLE_MODE_0,
    SCPMC_IDLE_MODE_1,
    SCPMC_IDLE_MODE_2
  } scpmc_mode_e;
endpackage
`default_nettype wire

// [verif/scpmc_chk.sv]
/* Checker for the clock and power mode block.
   Sees only the top module's ports; bound in from the bench. */
`default_nettype none
module scpmc_chk (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       halt_in,
  input wire logic       port_fall_wake_in,
  input wire logic       irq_wake_in,
  input wire logic       wdt_overflow_in,
  input wire logic       wdt_enabled_in,
  input wire logic       sys_clk_tick_out,
  input wire logic       hs_osc_run_out,
  input wire logic [1:0] hs_freq_sel_out,
  input wire logic       sub_clk_run_out,
  input wire logic       wdt_clk_run_out,
  input wire logic       cpu_hold_out,
  input wire logic [2:0] power_mode_out,
  input wire logic       power_down_set_out,
  input wire logic       timeout_clear_out,
  input wire logic       wdt_clear_out
);
  logic [1:0] keep_q;
  logic [2:0] exp_mode;
  logic       go_halt;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Shadow of the two keep bits as last written
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) keep_q <= 2'h0;
    else if (reg_wr_in && reg_addr_in == 2'h0) keep_q <= reg_wdata_in[1:0];
  end
  // Mode that a halt should pick, and halt taken in run
  always_comb begin
    case (keep_q)
      2'h0:    exp_mode = 3'h1;
      2'h1:    exp_mode = 3'h2;
      2'h3:    exp_mode = 3'h3;
      default: exp_mode = 3'h4;
    endcase
  end
  assign go_halt = halt_in && power_mode_out == 3'h0 && !cpu_hold_out;
  reserved_read_zero_a: assert property (
    $past(reg_rd_in && reg_addr_in == 2'h0) |-> reg_rdata_out[4:2] == 3'h0)
    else $error("unused control bits read non-zero");
  halt_mode_sel_a: assert property (
    go_halt |-> ##[1:3] power_mode_out == exp_mode) else $error("wrong halt mode");
  halt_flags_a: assert property (
    go_halt |-> ##[1:2] (power_down_set_out && timeout_clear_out && wdt_clear_out))
    else $error("halt flag pulses missing");
  flag_one_cycle_a: assert property (
    power_down_set_out |=> !power_down_set_out) else $error("flag pulse too long");
  sleep_clocks_a: assert property (
    power_mode_out == 3'h1 |-> !hs_osc_run_out && !sub_clk_run_out)
    else $error("clock running in sleep");
  idle_mode_0_clocks_a: assert property (
    power_mode_out == 3'h2 |-> !hs_osc_run_out && sub_clk_run_out)
    else $error("idle 0 clocks wrong");
  idle12_sub_a: assert property (
    power_mode_out > 3'h2 |-> sub_clk_run_out == (power_mode_out == 3'h3))
    else $error("idle 1 or 2 sub clock wrong");
  sleep_wdt_clk_a: assert property (
    power_mode_out == 3'h1 |-> wdt_clk_run_out == wdt_enabled_in)
    else $error("watchdog clock wrong in sleep");
  no_tick_halted_a: assert property (
    power_mode_out != 3'h0 && $past(power_mode_out) != 3'h0 |-> !sys_clk_tick_out)
    else $error("system tick while halted");
  wake_exit_a: assert property (
    power_mode_out != 3'h0 && (port_fall_wake_in || irq_wake_in || wdt_overflow_in)
    |-> ##[1:2] power_mode_out == 3'h0) else $error("no wake-up");
  freq_map_a: assert property (
    hs_freq_sel_out != 2'h3) else $error("frequency code 3 not mapped");
  cover property (go_halt && keep_q == 2'h0);
  cover property (go_halt && keep_q == 2'h3);
  cover property (power_mode_out == 3'h4 && wdt_overflow_in);
endmodule
`default_nettype wire

// [verif/scpmc_top_tb.sv]
/* Bench for the clock and power mode block.
   Drives every port itself; oscillator ticks follow the run outputs. */
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module scpmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [1:0] reg_addr_in = 2'h0, hs_freq_sel_out;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic hs_osc_tick_in = 1'b0, ls_osc_tick_in = 1'b0, hs_osc_ready_in = 1'b1;
  logic ls_osc_ready_in = 1'b1, halt_in = 1'b0, wdt_enabled_in = 1'b0;
  logic [2:0] wake = 3'h0, power_mode_out;
  logic [3:0] osc_cnt_q = 4'h0;
  logic sys_clk_tick_out, hs_osc_run_out, ls_osc_run_out, sub_clk_run_out;
  logic wdt_clk_run_out, cpu_hold_out, power_down_set_out, timeout_clear_out;
  logic wdt_clear_out;
  logic [2:0] mode_tbl [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  int errors = 0, comparisons = 0;
  scpmc_top scpmc_top_inst (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .hs_osc_tick_in, .hs_osc_ready_in,
    .ls_osc_tick_in, .ls_osc_ready_in, .halt_in, .port_fall_wake_in(wake[0]),
    .irq_wake_in(wake[1]), .wdt_overflow_in(wake[2]), .wdt_enabled_in,
    .sys_clk_tick_out, .hs_osc_run_out, .hs_freq_sel_out, .ls_osc_run_out,
    .sub_clk_run_out, .wdt_clk_run_out, .cpu_hold_out, .power_mode_out,
    .power_down_set_out, .timeout_clear_out, .wdt_clear_out);
  // Clock and oscillator ticks: fast every 2 cycles, slow every 16
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    osc_cnt_q <= osc_cnt_q + 4'h1;
    hs_osc_tick_in <= hs_osc_run_out && osc_cnt_q[0];
    ls_osc_tick_in <= ls_osc_run_out && osc_cnt_q == 4'hF;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 `CHK(reg_rdata_out, e)
  endtask
  // Skips two ticks, then counts cycles between the next two
  task automatic period(input int e);
    int n;
    n = 0;
    repeat (3) begin
      @(negedge clk_sys_in);
      while (sys_clk_tick_out !== 1'b1) @(negedge clk_sys_in);
    end
    do begin @(negedge clk_sys_in); n++; end while (sys_clk_tick_out !== 1'b1);
    `CHK(n, e)
  endtask
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h01);
    rd(2'h2, 8'h00);
    repeat (30) @(posedge clk_sys_in);
    rd(2'h1, 8'h03);
    `CHK(hs_freq_sel_out, 2'h0)
    wr(2'h0, 8'hFF);
    wr(2'h3, 8'h00);
    rd(2'h0, 8'hE3);
    wr(2'h1, 8'hF5);
    rd(2'h1, 8'h05);
    `CHK(hs_freq_sel_out, 2'h0)
    repeat (30) @(posedge clk_sys_in);
    rd(2'h1, 8'h07);
    `CHK(hs_freq_sel_out, 2'h1)
    wr(2'h1, 8'h0D);
    repeat (30) @(negedge clk_sys_in);
    `CHK(hs_freq_sel_out, 2'h0)
    wr(2'h1, 8'h09);
    repeat (30) @(negedge clk_sys_in);
    `CHK(hs_freq_sel_out, 2'h2)
    for (int i = 0; i < 7; i++) begin
      wr(2'h0, {i[2:0], 5'h00});
      period(2 << i);
    end
    ls_osc_ready_in <= 1'b0;
    wr(2'h0, 8'hE0);
    period(128);
    ls_osc_ready_in <= 1'b1;
    period(16);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h00);
    period(16);
    wr(2'h1, 8'h01);
    period(2);
    for (int k = 0; k < 4; k++) begin
      wdt_enabled_in <= k[0];
      wr(2'h0, {6'h00, k[1:0]});
      @(posedge clk_sys_in);
      halt_in <= 1'b1;
      @(posedge clk_sys_in);
      halt_in <= 1'b0;
      repeat (4) @(negedge clk_sys_in);
      `CHK(power_mode_out, mode_tbl[k])
      `CHK(cpu_hold_out, 1'b1)
      `CHK(ls_osc_run_out, k[0])
      @(posedge clk_sys_in);
      wake <= 3'h1 << (k % 3);
      @(posedge clk_sys_in);
      wake <= 3'h0;
      repeat (4) @(negedge clk_sys_in);
      `CHK(power_mode_out, 3'h0)
      rd(2'h0, {6'h00, k[1:0]});
    end
    report_and_stop();
  end
endmodule
bind scpmc_top scpmc_chk scpmc_chk_inst (.clk_sys_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .halt_in, .port_fall_wake_in,
  .irq_wake_in, .wdt_overflow_in, .wdt_enabled_in, .sys_clk_tick_out, .hs_osc_run_out,
  .hs_freq_sel_out, .sub_clk_run_out, .wdt_clk_run_out, .cpu_hold_out, .power_mode_out,
  .power_down_set_out, .timeout_clear_out, .wdt_clear_out);
`default_nettype wire
